// *** rtl/ir_adv_consts.svh ***
// register offsets, field positions and timing constants for the ir advanced bank
`ifndef IR_ADV_CONSTS_SVH
`define IR_ADV_CONSTS_SVH
`define OFS_DIV_LOW 3'h0
`define OFS_DIV_HIGH 3'h1
`define OFS_CTRL_ONE 3'h2
`define OFS_BANK_SEL 3'h3
`define OFS_CTRL_TWO 3'h4
`define OFS_TX_FILL 3'h6
`define OFS_RX_FILL 3'h7
`define BANK_SEL_READ 8'hE0
`define BANK_SEL_RESET 8'hE0
`define BANK_ADVANCED 8'hE0
`define CTRL_RESET 8'h00
`define C1_BAUD_OUT 7
`define C1_LOOP_PIN 5
`define C1_LOOP_ALL 4
`define C1_CH_SWAP 3
`define C1_THRESH 2
`define C1_FAIR 1
`define C1_ADV_SEL 0
`define C2_FB_DIS 7
`define C2_PRE_HI 5
`define C2_PRE_LO 4
`define C2_RX_HI 3
`define C2_RX_LO 2
`define C2_TX_HI 1
`define C2_TX_LO 0
`define TX_THR_LOW 6'h0D
`define TX_THR_HI16 6'h17
`define TX_THR_HI32 6'h07
`define RX_THR_LOW 6'h04
`define RX_THR_HIGH 6'h0A
`define FAIR_TIME_PS 10500000
`define CLK_PERIOD_PS 10000
`define FAIR_CYCLES (`FAIR_TIME_PS / `CLK_PERIOD_PS)
`define PRE_DIV13_HALF 26
`define PRE_DIV1625_HALF 13
`define PRE_DIV65_HALF 13
`define PRE_DIV1_HALF 2
`endif

// *** rtl/ir_adv_pkg.sv ***
// types for the ir advanced control bank
package ir_adv_pkg;
    typedef enum logic [1:0] {
        pre_div_13,
        pre_div_1p625,
        pre_div_6p5,
        pre_div_1
    } prescale_t;
    typedef enum logic [1:0] {
        dma_idle,
        dma_active,
        dma_backoff
    } dma_state_t;
endpackage

// *** rtl/ir_adv_bank.sv ***
// advanced-mode control bank of the infrared serial port
`timescale 1ns/1ps
`include "ir_adv_consts.svh"
module ir_adv_bank
    import ir_adv_pkg::*;
#(
    parameter int FAIR_CYCLES = `FAIR_CYCLES,
    parameter int FILL_W = 6
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic clk24,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    output logic [7:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic legacy_div_access,
    input wire logic fifo_enable,
    input wire logic [FILL_W-1:0] tx_fifo_count,
    input wire logic [FILL_W-1:0] rx_fifo_count,
    input wire logic dma_want,
    input wire logic tx_data,
    input wire logic dtr_normal,
    input wire logic dual_dma,
    input wire logic mir_fir_mode,
    output logic dtr_pin,
    output logic infrared_transmit_pin,
    output logic rx_loop_data,
    output logic loop_active,
    output logic advanced_mode,
    output logic baud_x16_tick,
    output logic [15:0] divisor,
    output logic dma_request_line,
    output logic dma_to_tx,
    output logic [5:0] tx_threshold,
    output logic [5:0] rx_threshold,
    output logic [5:0] rx_fifo_bytes,
    output logic [5:0] tx_fifo_bytes,
    output logic [7:0] bank_select_q
);
    initial begin
        if (FILL_W != 6)
            $error("fill level must be six bits wide");
        if (FAIR_CYCLES < 2)
            $error("fairness count too small");
    end

    logic [7:0] adv_divisor_low_q;
    logic [7:0] adv_divisor_high_q;
    logic [7:0] adv_control_one_q;
    logic [7:0] adv_control_two_q;
    logic rd_pending_q;
    logic wr_hit;
    logic rd_hit;
    logic fall_back;
    logic bank_here;

    // one wait cycle per access keeps read data registered; a write lands
    // at the edge where waitrequest is seen low, like a read completes
    assign rd_hit = avs_read && rd_pending_q;
    assign wr_hit = avs_write && clk_en && rd_pending_q;
    assign bank_here = (bank_select_q == `BANK_ADVANCED);
    assign fall_back = legacy_div_access && adv_control_one_q[`C1_ADV_SEL]
        && !adv_control_two_q[`C2_FB_DIS];

    function automatic logic [5:0] size_bytes(input logic [1:0] code);
        // reserved codes fall back to the small fifo
        size_bytes = (code == 2'b01) ? 6'h20 : 6'h10;
    endfunction

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            rd_pending_q <= 1'b0;
        else if (clk_en)
            rd_pending_q <= (avs_read || avs_write) && !rd_pending_q;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            avs_waitrequest <= 1'b1;
        else if (clk_en)
            avs_waitrequest <= !((avs_read || avs_write) && !rd_pending_q);
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            avs_readdata <= 8'h00;
        else if (clk_en && avs_read && !rd_pending_q)
        begin
            unique case (avs_address)
                `OFS_DIV_LOW: avs_readdata <= adv_divisor_low_q;
                `OFS_DIV_HIGH: avs_readdata <= adv_divisor_high_q;
                `OFS_CTRL_ONE: avs_readdata <= adv_control_one_q;
                `OFS_BANK_SEL: avs_readdata <= `BANK_SEL_READ;
                `OFS_CTRL_TWO: avs_readdata <= adv_control_two_q;
                `OFS_TX_FILL: avs_readdata <= {2'b00, tx_fifo_count};
                `OFS_RX_FILL: avs_readdata <= {2'b00, rx_fifo_count};
                default: avs_readdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            bank_select_q <= `BANK_SEL_RESET;
        else if (wr_hit && avs_address == `OFS_BANK_SEL)
            bank_select_q <= avs_writedata;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            adv_divisor_low_q <= 8'h00;
            adv_divisor_high_q <= 8'h00;
        end
        else if (wr_hit && bank_here)
        begin
            if (avs_address == `OFS_DIV_LOW)
                adv_divisor_low_q <= avs_writedata;
            if (avs_address == `OFS_DIV_HIGH)
                adv_divisor_high_q <= avs_writedata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            adv_control_one_q <= `CTRL_RESET;
        else if (clk_en)
        begin
            if (wr_hit && bank_here && avs_address == `OFS_CTRL_ONE)
                adv_control_one_q <= avs_writedata & 8'hBF;
            else if (fall_back)
            begin
                adv_control_one_q[`C1_ADV_SEL] <= 1'b0;
                adv_control_one_q[`C1_LOOP_PIN] <= 1'b0;
                adv_control_one_q[`C1_BAUD_OUT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            adv_control_two_q <= `CTRL_RESET;
        else if (wr_hit && bank_here && avs_address == `OFS_CTRL_TWO)
            adv_control_two_q <= avs_writedata & 8'hBF;
    end

    logic adv;
    assign adv = adv_control_one_q[`C1_ADV_SEL];

    // prescaler: 24 MHz pin sampled as a plain input, edges counted
    logic clk24_q;
    logic [5:0] pre_cnt_q;
    logic [5:0] pre_limit;
    logic pre_tick;
    logic [15:0] div_cnt_q;
    logic [3:0] os_cnt_q;
    logic baud_clk_q;
    prescale_t pre_sel;
    // the 1.625 divider approximated by a whole count of 3 half-edges; 6.5 is exactly 13 half-edges
    assign pre_sel = prescale_t'(adv_control_two_q[`C2_PRE_HI:`C2_PRE_LO]);
    always_comb
    begin
        unique case (pre_sel)
            pre_div_13: pre_limit = 6'(`PRE_DIV13_HALF);
            pre_div_1p625: pre_limit = 6'(`PRE_DIV1625_HALF / 4);
            pre_div_6p5: pre_limit = 6'(`PRE_DIV65_HALF);
            pre_div_1: pre_limit = 6'(`PRE_DIV1_HALF);
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            clk24_q <= 1'b0;
        else if (clk_en)
            clk24_q <= clk24;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
            pre_cnt_q <= 6'h00;
        else if (clk_en && (clk24 != clk24_q))
            pre_cnt_q <= (pre_cnt_q + 6'h01 >= pre_limit) ? 6'h00
                : pre_cnt_q + 6'h01;
    end
    assign pre_tick = clk_en && (clk24 != clk24_q)
        && (pre_cnt_q + 6'h01 >= pre_limit);

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            div_cnt_q <= 16'h0000;
            baud_x16_tick <= 1'b0;
        end
        else if (clk_en)
        begin
            baud_x16_tick <= 1'b0;
            if (pre_tick)
            begin
                if (div_cnt_q + 16'h0001 >= divisor)
                begin
                    div_cnt_q <= 16'h0000;
                    baud_x16_tick <= adv;
                end
                else
                    div_cnt_q <= div_cnt_q + 16'h0001;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            os_cnt_q <= 4'h0;
            baud_clk_q <= 1'b0;
        end
        else if (clk_en && baud_x16_tick)
        begin
            os_cnt_q <= os_cnt_q + 4'h1;
            baud_clk_q <= os_cnt_q[3];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            divisor <= 16'h0000;
            advanced_mode <= 1'b0;
            dtr_pin <= 1'b0;
            loop_active <= 1'b0;
            infrared_transmit_pin <= 1'b0;
            rx_loop_data <= 1'b0;
            dma_to_tx <= 1'b0;
            tx_threshold <= `TX_THR_LOW;
            rx_threshold <= `RX_THR_LOW;
            tx_fifo_bytes <= 6'h10;
            rx_fifo_bytes <= 6'h10;
        end
        else if (clk_en)
        begin
            divisor <= {adv_divisor_high_q, adv_divisor_low_q};
            advanced_mode <= adv;
            dtr_pin <= (adv && adv_control_one_q[`C1_BAUD_OUT]) ? baud_clk_q
                : dtr_normal;
            loop_active <= adv_control_one_q[`C1_LOOP_ALL];
            rx_loop_data <= tx_data;
            infrared_transmit_pin <= (!adv_control_one_q[`C1_LOOP_ALL]
                || (adv && adv_control_one_q[`C1_LOOP_PIN]))
                ? tx_data : 1'b0;
            dma_to_tx <= adv && mir_fir_mode
                && (dual_dma || adv_control_one_q[`C1_CH_SWAP]);
            if (adv_control_one_q[`C1_THRESH])
            begin
                tx_threshold <= (adv_control_two_q[`C2_TX_HI:`C2_TX_LO]
                    == 2'b01) ? `TX_THR_HI32 : `TX_THR_HI16;
                rx_threshold <= `RX_THR_HIGH;
            end
            else
            begin
                tx_threshold <= `TX_THR_LOW;
                rx_threshold <= `RX_THR_LOW;
            end
            if (fifo_enable)
            begin
                rx_fifo_bytes <= size_bytes(
                    adv_control_two_q[`C2_RX_HI:`C2_RX_LO]);
                tx_fifo_bytes <= size_bytes(
                    adv_control_two_q[`C2_TX_HI:`C2_TX_LO]);
            end
        end
    end

    // dma fairness: request dropped once held for the fairness time
    dma_state_t dma_state_q;
    logic [$clog2(FAIR_CYCLES+1)-1:0] fair_cnt_q;
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            dma_state_q <= dma_idle;
            fair_cnt_q <= '0;
            dma_request_line <= 1'b0;
        end
        else if (clk_en)
        begin
            unique case (dma_state_q)
                dma_idle:
                begin
                    fair_cnt_q <= '0;
                    if (dma_want && adv)
                    begin
                        dma_state_q <= dma_active;
                        dma_request_line <= 1'b1;
                    end
                end
                dma_active:
                begin
                    fair_cnt_q <= fair_cnt_q + 1'b1;
                    if (!dma_want || !adv)
                    begin
                        dma_state_q <= dma_idle;
                        dma_request_line <= 1'b0;
                    end
                    else if (!adv_control_one_q[`C1_FAIR]
                        && fair_cnt_q >= ($bits(fair_cnt_q))'(FAIR_CYCLES - 1))
                    begin
                        dma_state_q <= dma_backoff;
                        dma_request_line <= 1'b0;
                    end
                end
                dma_backoff:
                    if (!dma_want)
                        dma_state_q <= dma_idle;
                default:
                    dma_state_q <= dma_idle;
            endcase
        end
    end
endmodule // ir_adv_bank

// *** verif/ir_adv_bank_checker.sv ***
// port assertions for the advanced infrared control bank
`timescale 1ns/1ps
module ir_adv_bank_checker
#(
    parameter int FAIR_CYCLES = 8,
    parameter int FILL_W = 6
)
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [2:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    input wire logic [7:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic legacy_div_access,
    input wire logic fifo_enable,
    input wire logic [FILL_W-1:0] tx_fifo_count,
    input wire logic [FILL_W-1:0] rx_fifo_count,
    input wire logic dma_request_line,
    input wire logic advanced_mode,
    input wire logic [5:0] tx_threshold,
    input wire logic [5:0] rx_threshold,
    input wire logic [5:0] tx_fifo_bytes,
    input wire logic [5:0] rx_fifo_bytes,
    input wire logic [7:0] bank_select_q
);
    // shadow copies of the two control registers, seen from the bus
    logic [7:0] c1_q;
    logic [7:0] c2_q;
    int run_q;
    logic wr_ok;
    logic fall;
    assign wr_ok = avs_write && !avs_waitrequest && clk_en
        && bank_select_q == 8'hE0;
    assign fall = legacy_div_access && c1_q[0] && !(wr_ok && avs_address == 3'h2);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            c1_q <= 8'h00;
            c2_q <= 8'h00;
            run_q <= 0;
        end
        else
        begin
            if (wr_ok && avs_address == 3'h2)
                c1_q <= avs_writedata;
            else if (fall && !c2_q[7])
                c1_q <= c1_q & 8'h5E;
            if (wr_ok && avs_address == 3'h4)
                c2_q <= avs_writedata;
            run_q <= (dma_request_line && !c1_q[1]) ? run_q + 1 : 0;
        end
    end
    sequence rd_s(logic [2:0] a);
        avs_read && avs_waitrequest && avs_address == a;
    endsequence
    sequence wr_s(logic [2:0] a);
        wr_ok && avs_address == a;
    endsequence
    bank_read_a: assert property (rd_s(3'h3) |=> !avs_waitrequest && avs_readdata == 8'hE0) else $error("bank select read wrong");
    tx_depth_a: assert property (rd_s(3'h6) |=> avs_readdata == {2'b00, $past(tx_fifo_count[5:0])}) else $error("tx depth read wrong");
    rx_depth_a: assert property (rd_s(3'h7) |=> avs_readdata == {2'b00, $past(rx_fifo_count[5:0])}) else $error("rx depth read wrong");
    adv_select_a: assert property (wr_s(3'h2) |-> ##2 advanced_mode == c1_q[0]) else $error("advanced mode not selected");
    fallback_a: assert property (fall && !c2_q[7] |-> ##2 !advanced_mode) else $error("no fall back");
    fallback_off_a: assert property (fall && c2_q[7] |-> ##2 advanced_mode) else $error("fall back not disabled");
    rx_thresh_a: assert property (wr_s(3'h2) |-> ##2 rx_threshold == (c1_q[2] ? 6'h0A : 6'h04)) else $error("rx threshold wrong");
    tx_thresh_a: assert property (wr_s(3'h4) |-> ##2 tx_threshold == (!c1_q[2] ? 6'h0D : c2_q[1:0] == 2'b01 ? 6'h07 : 6'h17)) else $error("tx threshold wrong");
    fifo_size_a: assert property (wr_s(3'h4) && fifo_enable |-> ##2 tx_fifo_bytes == (c2_q[1:0] == 2'b01 ? 6'd32 : 6'd16) && rx_fifo_bytes == (c2_q[3:2] == 2'b01 ? 6'd32 : 6'd16)) else $error("fifo size wrong");
    fair_limit_a: assert property (run_q <= FAIR_CYCLES + 1) else $error("dma request held too long");
endmodule // ir_adv_bank_checker
bind ir_adv_bank ir_adv_bank_checker
    #(.FAIR_CYCLES(FAIR_CYCLES), .FILL_W(FILL_W)) chk (.*);

// *** verif/ir_transceiver_model.sv ***
// infrared transceiver stand-in counting light pulses on the transmit pin
`timescale 1ns/1ps
module ir_transceiver_model
(
    input wire logic clk,
    input wire logic infrared_transmit_pin,
    output int pulses
);
    logic last_q = 1'b0;
    initial pulses = 0;
    always @(posedge clk)
    begin
        last_q <= infrared_transmit_pin;
        if (infrared_transmit_pin && !last_q)
            pulses <= pulses + 1;
    end
endmodule // ir_transceiver_model

// *** verif/ir_adv_bank_tb.sv ***
// self-checking bench for the advanced infrared control bank
`timescale 1ns/1ps
module ir_adv_bank_tb;
    localparam int FC = 8;
    logic clk = 0, reset_n = 0, clk_en = 1, clk24, legacy_div_access = 0;
    logic [1:0] c24 = 0;
    logic [2:0] avs_address = 0;
    logic avs_read = 0, avs_write = 0, avs_waitrequest, fifo_enable = 1;
    logic [7:0] avs_writedata = 0, avs_readdata, bank_select_q, rd, e, lo, hi;
    logic [5:0] tx_fifo_count = 0, rx_fifo_count = 0;
    logic dma_want = 0, tx_data = 0, dtr_normal = 1, dual_dma = 0;
    logic mir_fir_mode = 1, dtr_pin, infrared_transmit_pin, rx_loop_data;
    logic loop_active, advanced_mode, baud_x16_tick, dma_request_line;
    logic dma_to_tx, lastd;
    logic [15:0] divisor;
    logic [5:0] tx_threshold, rx_threshold, rx_fifo_bytes, tx_fifo_bytes;
    int fails = 0, n_compared = 0, seed = 32'h5be6, n, k, d, pulses;
    int tk[4], f[4] = '{13000, 1625, 6500, 1000};
    assign clk24 = c24[1];
    initial forever #5 clk = ~clk;
    always @(posedge clk) c24 <= c24 + 2'd1;
    ir_adv_bank #(.FAIR_CYCLES(FC)) uut (.*);
    ir_transceiver_model far (.clk, .infrared_transmit_pin, .pulses);
    task automatic chk(string nm, logic [15:0] ex, logic [15:0] s);
        n_compared++;
        if (s !== ex)
        begin
            fails++;
            $display("unexpected %s expected %h seen %h", nm, ex, s);
        end
    endtask
    // write held until waitrequest is sampled low, then released
    task automatic wr(input logic [2:0] a, input logic [7:0] dat);
        avs_address <= a;
        avs_writedata <= dat;
        avs_write <= 1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            fails++;
        avs_write <= 0;
        repeat (2) @(posedge clk);
    endtask
    task automatic rdr(input logic [2:0] a);
        avs_address <= a;
        avs_read <= 1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (n >= 50)
            fails++;
        rd = avs_readdata;
        avs_read <= 0;
        @(posedge clk);
    endtask
    task automatic pulse_legacy();
        legacy_div_access <= 1;
        @(posedge clk);
        legacy_div_access <= 0;
        repeat (2) @(posedge clk);
    endtask
    task automatic toggle_tx();
        k = pulses;
        repeat (20) @(posedge clk) tx_data <= ~tx_data;
        repeat (3) @(posedge clk);
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    function automatic logic [5:0] txthr(logic t, logic [1:0] sz);
        return !t ? 6'h0D : (sz == 2'b01) ? 6'h07 : 6'h17;
    endfunction
    initial
    begin
        #500000;
        fails++;
        end_of_test();
    end
    initial
    begin
        tx_fifo_count <= $random(seed);
        rx_fifo_count <= $random(seed);
        repeat (6) @(posedge clk);
        reset_n <= 1;
        @(posedge clk);
        for (int i = 2; i < 8; i++)
        begin
            rdr(i[2:0]);
            e = i == 3 ? 8'hE0 : 8'h00;
            if (i > 5)
                e = {2'b00, i == 6 ? tx_fifo_count : rx_fifo_count};
            chk("reset read", e, rd);
        end
        repeat (4)
        begin
            lo = $random(seed);
            hi = $random(seed);
            wr(3'h0, lo);
            wr(3'h1, hi);
            chk("divisor", {hi, lo}, divisor);
            rdr(3'h1);
            chk("divisor high", hi, rd);
        end
        // another bank mapped: this bank's divisor writes must not land
        wr(3'h3, 8'hE8);
        chk("bank select", 8'hE8, bank_select_q);
        wr(3'h0, ~lo);
        rdr(3'h3);
        chk("bank read", 8'hE0, rd);
        chk("divisor kept", {hi, lo}, divisor);
        wr(3'h3, 8'hE0);
        wr(3'h2, 8'hF9);
        rdr(3'h2);
        chk("control one", 8'hB9, rd);
        chk("advanced", 1'b1, advanced_mode);
        pulse_legacy();
        rdr(3'h2);
        chk("fallback", 8'h18, rd);
        wr(3'h2, 8'hB9);
        wr(3'h4, 8'h80);
        pulse_legacy();
        rdr(3'h2);
        chk("fallback off", 8'hB9, rd);
        wr(3'h4, 8'h00);
        wr(3'h2, 8'h31);
        chk("loop", 1'b1, loop_active);
        toggle_tx();
        chk("pin pulses", 1'b1, pulses > k);
        chk("loop data", tx_data, rx_loop_data);
        wr(3'h2, 8'h11);
        toggle_tx();
        chk("pin quiet", 1'b0, pulses != k);
        wr(3'h2, 8'h09);
        chk("swap tx", 1'b1, dma_to_tx);
        for (int fb = 0; fb < 2; fb++)
        begin
            wr(3'h2, {6'h00, fb[0], 1'b1});
            chk("swap rx", 1'b0, dma_to_tx);
            dma_want <= 1;
            repeat (3) @(posedge clk);
            d = 0;
            repeat (3 * FC) @(posedge clk) d += dma_request_line;
            dma_want <= 0;
            if (fb == 0)
                chk("fair drop", 1'b1, d > 0 && d < 3 * FC);
            else
                chk("fair hold", 3 * FC, d);
        end
        for (int t = 0; t < 2; t++)
            for (int s = 0; s < 4; s++)
            begin
                wr(3'h2, {5'h00, t[0], 2'b01});
                wr(3'h4, {4'h0, s[1:0], s[1:0]});
                chk("tx thr", txthr(t[0], s[1:0]), tx_threshold);
                chk("rx thr", t ? 6'h0A : 6'h04, rx_threshold);
                e = s == 1 ? 8'd32 : 8'd16;
                chk("tx size", e, tx_fifo_bytes);
                chk("rx size", e, rx_fifo_bytes);
            end
        wr(3'h0, 8'h01);
        wr(3'h1, 8'h00);
        wr(3'h2, 8'h81);
        d = 0;
        lastd = dtr_pin;
        for (int c = 0; c < 4; c++)
        begin
            wr(3'h4, {2'b00, c[1:0], 4'h0});
            tk[c] = 0;
            repeat (4000)
            begin
                @(posedge clk);
                tk[c] += baud_x16_tick;
                d += dtr_pin !== lastd;
                lastd = dtr_pin;
            end
        end
        chk("baud on dtr", 1'b1, d > 0);
        chk("ticks", 1'b1, tk[3] > 100);
        for (int c = 0; c < 3; c++)
        begin
            k = tk[c] * f[c] - tk[3] * 1000;
            n = tk[3] * (c == 1 ? 250 : 100);
            chk("prescale", 1'b1, (k < 0 ? -k : k) <= n);
        end
        wr(3'h2, 8'h01);
        dtr_normal <= 0;
        repeat (3) @(posedge clk);
        chk("dtr normal", 1'b0, dtr_pin);
        end_of_test();
    end
endmodule // ir_adv_bank_tb
